// File: pkg/fcss_pkg.sv
/*
 * Constants and the sector-index helper shared by both ends of the flash command
 * and status sequencer. Assumes one 25 MHz clock for both ends.
 */
`default_nettype none
package fcss_pkg;
	localparam int CLK_MHZ = 25;
	localparam int NSECT = 12;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam logic [15:0] UNLK_ADDR1 = 16'h0AAA;
	localparam logic [15:0] UNLK_ADDR2 = 16'h0554;
	localparam logic [7:0] CMD_UNLK1 = 8'hAA;
	localparam logic [7:0] CMD_UNLK2 = 8'h55;
	localparam logic [7:0] CMD_PROG = 8'hA0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_BULK = 8'h10;
	localparam logic [7:0] CMD_SECT = 8'h30;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
	localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam int POLL_BIT = 7;
	localparam int TOG_BIT = 6;
	localparam int ERR_BIT = 5;
	localparam int WIN_BIT = 3;
	localparam int WIN_US = 100;
	localparam int RST_US = 25;
	localparam int SUSP_NS = 1000;
	localparam int PROG_US = 10;
	localparam int ERASE_US = 1000;
	localparam int WIN_CYC = WIN_US * CLK_MHZ;
	localparam int RST_CYC = RST_US * CLK_MHZ;
	localparam int SUSP_CYC = SUSP_NS * CLK_MHZ / 1000;
	localparam int PROG_CYC = PROG_US * CLK_MHZ;
	localparam int TMR_W = 24;
	localparam logic [15:0] INVALID_WORD = 16'h5A5A;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [7:0] HOFS_ADDR = 8'h00;
	localparam logic [7:0] HOFS_WDATA = 8'h04;
	localparam logic [7:0] HOFS_SEL = 8'h08;
	localparam logic [7:0] HOFS_CTRL = 8'h0C;
	localparam logic [7:0] HOFS_RDATA = 8'h10;
	localparam logic [7:0] HOFS_STAT = 8'h14;
	localparam logic [7:0] HOFS_PROT = 8'h18;
	localparam int CTRL_WR = 0;
	localparam int CTRL_RD = 1;
	localparam int CTRL_POLL = 2;
	localparam int STAT_BUSY = 0;
	localparam int STAT_OK = 1;
	localparam int STAT_FAIL = 2;

	function automatic logic [3:0] fcss_sect_idx(input logic [NSECT-1:0] s);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < NSECT; i++) begin
			if (s[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// File: pkg/fcss_if.sv
/*
 * Parallel memory bus between the controller and the flash sequencer.
 * Assumes both ends run on the same clock; strobes last one cycle.
 */
`default_nettype none
interface fcss_if;
	import fcss_pkg::*;
	logic wrStb;
	logic rdStb;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [NSECT-1:0] sectSel;
	logic [DATA_W-1:0] rdata;
	logic rdValid;
	logic [NSECT-1:0] protStatus;
	modport dev(input wrStb, rdStb, addr, wdata, sectSel,
		output rdata, rdValid, protStatus);
	modport host(output wrStb, rdStb, addr, wdata, sectSel,
		input rdata, rdValid, protStatus);
endinterface
`default_nettype wire

// File: logic/fcss_device.sv
/*
 * Flash command decoder, embedded algorithm timing and status bits,
 * with a small word array per sector. Assumes the controller drives
 * one-cycle strobes on the same clock and a one-hot sector select.
 */
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`default_nettype none
module fcss_device import fcss_pkg::*; #(
	parameter int ERASE_TIME_US = ERASE_US,
	parameter int WPS_AW = 2,
	parameter bit BIG_END = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	fcss_if.dev bus,
	input wire logic [NSECT-1:0] protectBits,
	input wire logic forceFail,
	output logic busy
);
	localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
	localparam int NWORD = NSECT << WPS_AW;
	localparam int IDX_W = 4 + WPS_AW;

	if (WPS_AW < 1 || WPS_AW > 8 || ERASE_CYC >= (1 << TMR_W)) begin : g_chk
		$error("fcss_device: unsupported parameters");
	end

	typedef enum logic [4:0] {
		S_READ, S_UNLK1, S_UNLK2, S_PADDR, S_PROGRAM, S_EUNLK0, S_EUNLK1,
		S_ECMD, S_BULK, S_SWIN, S_SERASE, S_SPEND, S_SUSP, S_ERR,
		S_RSTW, S_BYP, S_BPROG, S_BEXIT
	} fcss_state_t;

	fcss_state_t stateFf, nxt_state;
	logic [TMR_W-1:0] timerFf, nxt_timer, remFf, nxt_rem;
	logic [NSECT-1:0] maskFf, nxt_mask;
	logic bypFf, nxt_byp, errFf, nxt_err, badFf, nxt_bad;
	logic [IDX_W-1:0] tgtIdxFf, nxt_tgtIdx;
	logic [15:0] tgtDataFf, nxt_tgtData;
	logic [15:0] mem [NWORD];
	logic memWr, fillGo;
	logic [15:0] fillVal;
	logic [NSECT-1:0] fillMask;
	logic togFf, statHit, tDone, isReset, atUnlk1, atUnlk2, suspCmd;
	logic resumeCmd, secHit, okSect;
	logic [3:0] secIdx;
	logic [IDX_W-1:0] wIdx;
	logic [7:0] wb, statByte;
	logic [15:0] rdataFf;
	logic rdValidFf;

	assign wb = bus.wdata[7:0];
	assign secHit = |bus.sectSel;
	assign secIdx = fcss_sect_idx(bus.sectSel);
	assign wIdx = {secIdx, bus.addr[WPS_AW:1]};
	assign tDone = (timerFf == '0);
	assign isReset = bus.wrStb && wb == CMD_RESET;
	assign atUnlk1 = bus.wrStb && wb == CMD_UNLK1 && bus.addr == UNLK_ADDR1;
	assign atUnlk2 = bus.wrStb && wb == CMD_UNLK2 && bus.addr == UNLK_ADDR2;
	assign suspCmd = bus.wrStb && wb == CMD_SUSPEND && !bus.addr[0]
		&& secHit;
	assign resumeCmd = bus.wrStb && wb == CMD_RESUME && !bus.addr[0]
		&& secHit;
	assign okSect = secHit && !protectBits[secIdx];

	always_comb begin
		nxt_state = stateFf;
		nxt_timer = tDone ? timerFf : timerFf - 1'b1;
		nxt_rem = remFf;
		nxt_mask = maskFf;
		nxt_byp = bypFf;
		nxt_err = errFf;
		nxt_bad = badFf;
		nxt_tgtIdx = tgtIdxFf;
		nxt_tgtData = tgtDataFf;
		memWr = 1'b0;
		fillGo = 1'b0;
		fillVal = 16'h0000;
		fillMask = '0;
		unique case (stateFf)
			S_READ: begin
				if (atUnlk1) begin
					nxt_state = S_UNLK1;
				end
			end
			S_UNLK1: begin
				if (bus.wrStb) begin
					nxt_state = atUnlk2 ? S_UNLK2 : S_READ;
				end
			end
			S_UNLK2: begin
				if (bus.wrStb) begin
					nxt_state = S_READ;
					if (bus.addr == UNLK_ADDR1 && wb == CMD_PROG) begin
						nxt_state = S_PADDR;
					end
					if (bus.addr == UNLK_ADDR1 && wb == CMD_ERASE) begin
						nxt_state = S_EUNLK0;
					end
					if (bus.addr == UNLK_ADDR1 && wb == CMD_BYPASS) begin
						nxt_state = S_BYP;
						nxt_byp = 1'b1;
					end
				end
			end
			S_PADDR, S_BPROG: begin
				if (bus.wrStb) begin
					nxt_state = bypFf ? S_BYP : S_READ;
					if (okSect) begin
						nxt_state = S_PROGRAM;
						nxt_tgtIdx = wIdx;
						nxt_tgtData = bus.wdata;
						nxt_bad = |(bus.wdata & ~mem[wIdx]);
						nxt_timer = TMR_W'(PROG_CYC);
					end
				end
			end
			S_PROGRAM: begin
				// writes here, reset included, fall on the floor
				if (tDone) begin
					if (badFf || forceFail) begin
						nxt_state = S_ERR;
						nxt_err = 1'b1;
					end else begin
						memWr = 1'b1;
						nxt_state = bypFf ? S_BYP : S_READ;
					end
				end
			end
			S_EUNLK0: begin
				if (bus.wrStb) begin
					nxt_state = atUnlk1 ? S_EUNLK1 : S_READ;
				end
			end
			S_EUNLK1: begin
				if (bus.wrStb) begin
					nxt_state = atUnlk2 ? S_ECMD : S_READ;
				end
			end
			S_ECMD: begin
				if (bus.wrStb) begin
					nxt_state = S_READ;
					if (wb == CMD_BULK && bus.addr == UNLK_ADDR1) begin
						nxt_state = S_BULK;
						fillGo = 1'b1;
						fillMask = ~protectBits;
						nxt_timer = TMR_W'(ERASE_CYC);
					end else if (wb == CMD_SECT && secHit) begin
						nxt_state = S_SWIN;
						nxt_mask = okSect ? bus.sectSel : '0;
						nxt_timer = TMR_W'(WIN_CYC);
					end
				end
			end
			S_BULK: begin
				if (tDone) begin
					if (forceFail) begin
						nxt_state = S_ERR;
						nxt_err = 1'b1;
					end else begin
						nxt_state = S_READ;
						fillGo = 1'b1;
						fillVal = ERASED_WORD;
						fillMask = ~protectBits;
					end
				end
			end
			S_SWIN: begin
				if (bus.wrStb && wb == CMD_SECT && secHit) begin
					nxt_timer = TMR_W'(WIN_CYC);
					if (okSect) begin
						nxt_mask = maskFf | bus.sectSel;
					end
				end else if (suspCmd) begin
					nxt_state = S_SPEND;
					fillGo = 1'b1;
					fillMask = maskFf;
					nxt_rem = TMR_W'(ERASE_CYC);
					nxt_timer = TMR_W'(SUSP_CYC);
				end else if (bus.wrStb) begin
					nxt_state = S_READ;
					nxt_mask = '0;
				end else if (tDone) begin
					// all-protected selection just times out to read
					nxt_state = (maskFf == '0) ? S_READ : S_SERASE;
					fillGo = 1'b1;
					fillMask = maskFf;
					nxt_timer = TMR_W'(ERASE_CYC);
				end
			end
			S_SERASE: begin
				if (isReset) begin
					nxt_state = S_RSTW;
					nxt_timer = TMR_W'(RST_CYC);
				end else if (suspCmd) begin
					nxt_state = S_SPEND;
					nxt_rem = timerFf;
					nxt_timer = TMR_W'(SUSP_CYC);
				end else if (tDone) begin
					if (forceFail) begin
						nxt_state = S_ERR;
						nxt_err = 1'b1;
					end else begin
						nxt_state = S_READ;
						fillGo = 1'b1;
						fillVal = ERASED_WORD;
						fillMask = maskFf;
						nxt_mask = '0;
					end
				end
			end
			S_SPEND: begin
				if (tDone) begin
					nxt_state = S_SUSP;
				end
			end
			S_SUSP: begin
				if (resumeCmd) begin
					nxt_state = S_SERASE;
					nxt_timer = remFf;
				end else if (isReset) begin
					nxt_state = S_RSTW;
					nxt_timer = TMR_W'(RST_CYC);
				end
			end
			S_ERR: begin
				if (isReset) begin
					nxt_state = S_RSTW;
					nxt_timer = TMR_W'(RST_CYC);
				end
			end
			S_RSTW: begin
				if (tDone) begin
					nxt_state = S_READ;
					nxt_err = 1'b0;
					nxt_mask = '0;
					nxt_byp = 1'b0;
				end
			end
			S_BYP: begin
				if (bus.wrStb && wb == CMD_PROG) begin
					nxt_state = S_BPROG;
				end else if (bus.wrStb && wb == CMD_BYP_EXIT1) begin
					nxt_state = S_BEXIT;
				end
				// anything else is dropped in bypass mode
			end
			S_BEXIT: begin
				if (bus.wrStb) begin
					nxt_state = (wb == CMD_BYP_EXIT2) ? S_READ : S_BYP;
					nxt_byp = (wb != CMD_BYP_EXIT2);
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stateFf <= S_READ;
			timerFf <= '0;
			remFf <= '0;
			maskFf <= '0;
			bypFf <= 1'b0;
			errFf <= 1'b0;
			badFf <= 1'b0;
			tgtIdxFf <= '0;
			tgtDataFf <= 16'h0000;
		end else begin
			stateFf <= nxt_state;
			timerFf <= nxt_timer;
			remFf <= nxt_rem;
			maskFf <= nxt_mask;
			bypFf <= nxt_byp;
			errFf <= nxt_err;
			badFf <= nxt_bad;
			tgtIdxFf <= nxt_tgtIdx;
			tgtDataFf <= nxt_tgtData;
		end
	end

	// the array comes out of reset erased; programming only clears bits
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < NWORD; i++) begin
			if (!rst_n) begin
				mem[i] <= ERASED_WORD;
			end else if (fillGo && fillMask[i >> WPS_AW]) begin
				mem[i] <= fillVal;
			end else if (memWr && tgtIdxFf == IDX_W'(i)) begin
				mem[i] <= mem[i] & tgtDataFf;
			end
		end
	end

	always_comb begin
		unique case (stateFf)
			S_PROGRAM: statHit = (wIdx == tgtIdxFf);
			S_BULK, S_ERR, S_RSTW: statHit = 1'b1;
			S_SWIN, S_SERASE, S_SPEND: begin
				statHit = secHit && maskFf[secIdx] && !bus.addr[0];
			end
			default: statHit = 1'b0;
		endcase
	end

	assign statByte = {stateFf == S_PROGRAM && !tgtDataFf[POLL_BIT],
		!togFf, errFf, 1'b0, stateFf != S_SWIN, 3'b000};

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			togFf <= 1'b0;
		end else if (bus.rdStb && statHit) begin
			togFf <= !togFf;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdValidFf <= 1'b0;
			rdataFf <= 16'h0000;
		end else begin
			rdValidFf <= bus.rdStb;
			if (bus.rdStb) begin
				if (statHit) begin
					rdataFf <= BIG_END ? {statByte, 8'h00}
						: {8'h00, statByte};
				end else if (stateFf == S_SUSP && secHit && maskFf[secIdx]) begin
					rdataFf <= INVALID_WORD;
				end else begin
					rdataFf <= mem[wIdx];
				end
			end
		end
	end

	assign bus.rdata = rdataFf;
	assign bus.rdValid = rdValidFf;
	assign bus.protStatus = protectBits;
	assign busy = !(stateFf inside {S_READ, S_UNLK1, S_UNLK2, S_PADDR,
		S_EUNLK0, S_EUNLK1, S_ECMD, S_SUSP, S_BYP, S_BPROG, S_BEXIT});
endmodule
`default_nettype wire

// File: logic/fcss_host.sv
/*
 * Controller end: AHB-Lite register slave that issues bus cycles to the
 * flash sequencer and runs the toggle-bit completion check. Assumes a
 * single AHB-Lite master and the sequencer on the same clock.
 */
`default_nettype none
module fcss_host import fcss_pkg::*; #(
	parameter bit BIG_END = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	fcss_if.host bus,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	typedef enum logic [1:0] {H_IDLE, H_RD, H_PISSUE, H_PWAIT} fcss_hstate_t;

	fcss_hstate_t hstFf;
	logic [15:0] addrFf, wdataFf, rdFf, prevFf;
	logic [NSECT-1:0] selFf;
	logic wrStbFf, rdStbFf, okFf, failFf, firstFf, errChkFf;
	logic aphWrFf;
	logic [7:0] aphAddrFf;
	logic [31:0] hrdataFf, rdMux;
	logic ctrlWr;
	logic [7:0] stat, prevStat;

	assign stat = BIG_END ? bus.rdata[15:8] : bus.rdata[7:0];
	assign prevStat = BIG_END ? prevFf[15:8] : prevFf[7:0];
	assign ctrlWr = aphWrFf && aphAddrFf == HOFS_CTRL && hstFf == H_IDLE;

	always_comb begin
		unique case (hsel ? haddr[7:0] : 8'hFF)
			HOFS_ADDR: rdMux = {16'h0000, addrFf};
			HOFS_WDATA: rdMux = {16'h0000, wdataFf};
			HOFS_SEL: rdMux = {20'h00000, selFf};
			HOFS_RDATA: rdMux = {16'h0000, rdFf};
			HOFS_STAT: rdMux = {29'h00000000, failFf, okFf, hstFf != H_IDLE};
			HOFS_PROT: rdMux = {20'h00000, bus.protStatus};
			default: rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aphWrFf <= 1'b0;
			aphAddrFf <= 8'h00;
			hrdataFf <= 32'h00000000;
		end else if (hready) begin
			aphWrFf <= hsel && htrans[1] && hwrite;
			aphAddrFf <= haddr[7:0];
			hrdataFf <= rdMux;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			addrFf <= 16'h0000;
			wdataFf <= 16'h0000;
			selFf <= '0;
		end else if (aphWrFf) begin
			if (aphAddrFf == HOFS_ADDR) begin
				addrFf <= hwdata[15:0];
			end
			if (aphAddrFf == HOFS_WDATA) begin
				wdataFf <= hwdata[15:0];
			end
			if (aphAddrFf == HOFS_SEL) begin
				selFf <= hwdata[NSECT-1:0];
			end
		end
	end

	// a command write while a read or poll is under way is dropped
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hstFf <= H_IDLE;
			wrStbFf <= 1'b0;
			rdStbFf <= 1'b0;
			okFf <= 1'b0;
			failFf <= 1'b0;
			firstFf <= 1'b0;
			errChkFf <= 1'b0;
			rdFf <= 16'h0000;
			prevFf <= 16'h0000;
		end else begin
			wrStbFf <= 1'b0;
			rdStbFf <= 1'b0;
			unique case (hstFf)
				H_IDLE: begin
					if (ctrlWr && hwdata[CTRL_WR]) begin
						wrStbFf <= 1'b1;
					end else if (ctrlWr && hwdata[CTRL_RD]) begin
						rdStbFf <= 1'b1;
						hstFf <= H_RD;
					end else if (ctrlWr && hwdata[CTRL_POLL]) begin
						okFf <= 1'b0;
						failFf <= 1'b0;
						firstFf <= 1'b1;
						errChkFf <= 1'b0;
						hstFf <= H_PISSUE;
					end
				end
				H_RD: begin
					if (bus.rdValid) begin
						rdFf <= bus.rdata;
						hstFf <= H_IDLE;
					end
				end
				H_PISSUE: begin
					rdStbFf <= 1'b1;
					hstFf <= H_PWAIT;
				end
				H_PWAIT: begin
					if (bus.rdValid) begin
						rdFf <= bus.rdata;
						prevFf <= bus.rdata;
						firstFf <= 1'b0;
						hstFf <= H_PISSUE;
						// toggling stopped means done even after an error bit:
						// the last read may already carry plain array data
						if (!firstFf && stat[TOG_BIT] == prevStat[TOG_BIT]) begin
							okFf <= 1'b1;
							failFf <= 1'b0;
							hstFf <= H_IDLE;
						end else if (!firstFf && errChkFf) begin
							failFf <= 1'b1;
							hstFf <= H_IDLE;
						end else if (stat[ERR_BIT]) begin
							errChkFf <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	assign bus.wrStb = wrStbFf;
	assign bus.rdStb = rdStbFf;
	assign bus.addr = addrFf;
	assign bus.wdata = wdataFf;
	assign bus.sectSel = selFf;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdataFf;
endmodule
`default_nettype wire

// File: tb/fcss_asserts.sv
/*
 * Checker for the flash bus between the controller and the sequencer.
 * Assumes the bench instantiates it beside the interface, on ref_clk.
 */
`default_nettype none
module fcss_asserts import fcss_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic rdValid,
	input wire logic [NSECT-1:0] protStatus,
	input wire logic [NSECT-1:0] protectBits,
	input wire logic busy
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	a_read_answer: assert property (rdStb |=> rdValid ##1 !rdValid)
		else $error("read not answered by one valid pulse");
	a_valid_cause: assert property (rdValid |-> $past(rdStb))
		else $error("read valid without a read strobe");
	// rdata must hold so a slow poller still sees the last answer
	a_rdata_hold: assert property (!rdValid |-> $stable(rdata))
		else $error("read data changed without a read");
	a_strobe_gap: assert property ((wrStb || rdStb) |=> !(wrStb || rdStb))
		else $error("strobes closer than two cycles");
	a_strobe_excl: assert property (!(wrStb && rdStb))
		else $error("read and write strobe together");
	a_prot_mirror: assert property (protStatus == protectBits)
		else $error("protection status differs from protection bits");
	a_busy_cause: assert property ($rose(busy) |-> $past(wrStb))
		else $error("algorithm started without a write");
	a_reset_state: assert property ($rose(rst_n) |->
		!busy && !rdValid && rdata == '0)
		else $error("state not cleared by reset");
endmodule
`default_nettype wire

// File: tb/tb_flash_command_status_sequencer.sv
/*
 * Bench: AHB-Lite master on the controller, both ends joined by the
 * interface. Assumes zero-wait-state registers and a short erase time.
 */
`default_nettype none
module tb_flash_command_status_sequencer import fcss_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [NSECT-1:0] protectBits = '0;
	logic forceFail = 1'b0;
	logic busy;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [31:0] r;
	logic [31:0] r2;
	logic [31:0] s;
	logic [15:0] dA;
	logic [15:0] dB;

	fcss_if busIf ();
	// short erase keeps the run small; window and reset waits stay real
	fcss_device #(.ERASE_TIME_US(40)) u_fcss_device (.ref_clk(ref_clk),
		.rst_n(rst_n), .bus(busIf), .protectBits(protectBits),
		.forceFail(forceFail), .busy(busy));
	fcss_host u_fcss_host (.ref_clk(ref_clk), .rst_n(rst_n), .bus(busIf),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	fcss_asserts u_fcss_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
		.wrStb(busIf.wrStb), .rdStb(busIf.rdStb), .rdata(busIf.rdata),
		.rdValid(busIf.rdValid), .protStatus(busIf.protStatus),
		.protectBits(protectBits), .busy(busy));

	always #20 ref_clk = ~ref_clk;

	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] prog_status(input logic [15:0] d);
		return {24'h0, ~d[POLL_BIT], 7'h08};
	endfunction

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	task automatic go(input logic [15:0] a, input logic [11:0] sel,
		input logic [31:0] ctl, output logic [31:0] st);
		wr(HOFS_ADDR, {16'h0, a});
		wr(HOFS_SEL, {20'h0, sel});
		wr(HOFS_CTRL, ctl);
		do ahb(1'b0, HOFS_STAT, 32'h0, st); while (st[STAT_BUSY] !== 1'b0);
	endtask

	task automatic op(input logic [15:0] a, input logic [7:0] c,
		input logic [11:0] sel);
		logic [31:0] x;
		wr(HOFS_WDATA, {24'h0, c});
		go(a, sel, 32'h1, x);
	endtask

	task automatic dat(input logic [15:0] a, input logic [15:0] d,
		input logic [11:0] sel);
		logic [31:0] x;
		wr(HOFS_WDATA, {16'h0, d});
		go(a, sel, 32'h1, x);
	endtask

	task automatic rdf(input logic [15:0] a, input logic [11:0] sel,
		output logic [31:0] d);
		logic [31:0] x;
		go(a, sel, 32'h2, x);
		ahb(1'b0, HOFS_RDATA, 32'h0, d);
	endtask

	task automatic poll(input logic [15:0] a, input logic [11:0] sel,
		output logic [31:0] st);
		go(a, sel, 32'h4, st);
		st = st & 32'h6;
	endtask

	task automatic unlk(input logic [11:0] sel);
		op(UNLK_ADDR1, CMD_UNLK1, sel);
		op(UNLK_ADDR2, CMD_UNLK2, sel);
	endtask

	task automatic prog(input logic [15:0] a, input logic [11:0] sel,
		input logic [15:0] d);
		unlk(sel);
		op(UNLK_ADDR1, CMD_PROG, sel);
		dat(a, d, sel);
	endtask

	task automatic erase_pre(input logic [11:0] sel);
		unlk(sel);
		op(UNLK_ADDR1, CMD_ERASE, sel);
		unlk(sel);
	endtask

	initial begin
		void'($urandom(46));
		dA = 16'($urandom) & 16'hFFFE;
		// odd low byte keeps a refused data write from decoding as a command
		dB = 16'($urandom) | 16'h0001;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		protectBits <= 12'h020 | (12'($urandom) & 12'hFC0);
		for (int i = 0; i < 8; i++) begin
			ahb(1'b0, 8'(i * 4), 32'h0, r);
			chk(r, (i == 6) ? {20'h0, protectBits} : 32'h0);
			chk({31'h0, hresp}, 32'h0);
		end
		for (int i = 0; i < 3; i++) begin
			r = $urandom;
			wr(8'(i * 4), r);
			ahb(1'b0, 8'(i * 4), 32'h0, r2);
			chk(r2, r & ((i == 2) ? 32'hFFF : 32'hFFFF));
		end
		wr(8'h1C, 32'hFFFFFFFF);
		wr(HOFS_PROT, $urandom);
		ahb(1'b0, 8'h1C, 32'h0, r);
		chk(r, 32'h0);
		ahb(1'b0, HOFS_PROT, 32'h0, r);
		chk(r, {20'h0, protectBits});
		// program with status reads at the worked-on word
		prog(16'h0, 12'h004, dB);
		rdf(16'h0, 12'h004, r);
		rdf(16'h0, 12'h004, r2);
		chk(r ^ r2, 32'h40);
		chk(r & 32'hFFFFFFBF, prog_status(dB));
		poll(16'h0, 12'h004, s);
		chk(s, 32'h2);
		rdf(16'h0, 12'h004, r);
		chk(r, {16'h0, dB});
		// program a 0 back to 1: error, then reset waits
		prog(16'h2, 12'h010, dA);
		poll(16'h2, 12'h010, s);
		prog(16'h2, 12'h010, ~dA);
		poll(16'h2, 12'h010, s);
		chk(s, 32'h4);
		rdf(16'h2, 12'h010, r);
		chk(r & 32'h20, 32'h20);
		op(UNLK_ADDR1, CMD_RESET, 12'h010);
		repeat (580) @(posedge ref_clk);
		chk({31'h0, busy}, 32'h1);
		repeat (60) @(posedge ref_clk);
		chk({31'h0, busy}, 32'h0);
		// bypass mode
		unlk(12'h004);
		op(UNLK_ADDR1, CMD_BYPASS, 12'h004);
		op(UNLK_ADDR1, CMD_PROG, 12'h004);
		dat(16'h2, dA, 12'h004);
		poll(16'h2, 12'h004, s);
		op(UNLK_ADDR1, CMD_RESET, 12'h004);
		op(UNLK_ADDR1, CMD_PROG, 12'h004);
		dat(16'h4, dB, 12'h004);
		poll(16'h4, 12'h004, s);
		op(16'($urandom), CMD_BYP_EXIT1, 12'h004);
		op(16'($urandom), CMD_BYP_EXIT2, 12'h004);
		op(UNLK_ADDR1, CMD_PROG, 12'h004);
		dat(16'h6, dA, 12'h004);
		chk({31'h0, busy}, 32'h0);
		rdf(16'h2, 12'h004, r);
		chk(r, {16'h0, dA});
		rdf(16'h4, 12'h004, r);
		chk(r, {16'h0, dB});
		rdf(16'h6, 12'h004, r);
		chk(r, 32'hFFFF);
		// two-sector erase with window restart, suspend, resume
		prog(16'h0, 12'h001, dA);
		poll(16'h0, 12'h001, s);
		prog(16'h0, 12'h002, dA);
		poll(16'h0, 12'h002, s);
		erase_pre(12'h001);
		op(16'h0, CMD_SECT, 12'h001);
		rdf(16'h0, 12'h001, r);
		chk(r & 32'h8, 32'h0);
		repeat (1500) @(posedge ref_clk);
		op(16'h0, CMD_SECT, 12'h002);
		repeat (1500) @(posedge ref_clk);
		rdf(16'h0, 12'h001, r);
		chk(r & 32'h8, 32'h0);
		repeat (1100) @(posedge ref_clk);
		rdf(16'h0, 12'h001, r);
		chk(r & 32'h8, 32'h8);
		op(16'h0, CMD_SUSPEND, 12'h001);
		repeat (40) @(posedge ref_clk);
		chk({31'h0, busy}, 32'h0);
		rdf(16'h0, 12'h001, r);
		rdf(16'h0, 12'h001, r2);
		chk(r ^ r2, 32'h0);
		rdf(16'h1, 12'h001, r);
		chk(r, {16'h0, INVALID_WORD});
		rdf(16'h0, 12'h004, r);
		chk(r, {16'h0, dB});
		prog(16'h6, 12'h004, dB);
		op(16'h0, CMD_RESUME, 12'h001);
		chk({31'h0, busy}, 32'h1);
		poll(16'h0, 12'h001, s);
		chk(s, 32'h2);
		rdf(16'h0, 12'h001, r);
		chk(r, 32'hFFFF);
		rdf(16'h0, 12'h002, r);
		chk(r, 32'hFFFF);
		rdf(16'h6, 12'h004, r);
		chk(r, 32'hFFFF);
		// another command inside the window aborts the erase
		prog(16'h0, 12'h008, dA);
		poll(16'h0, 12'h008, s);
		erase_pre(12'h008);
		op(16'h0, CMD_SECT, 12'h008);
		op(UNLK_ADDR1, CMD_PROG, 12'h008);
		chk({31'h0, busy}, 32'h0);
		rdf(16'h0, 12'h008, r);
		chk(r, {16'h0, dA});
		prog(16'h0, 12'h020, dA);
		chk({31'h0, busy}, 32'h0);
		rdf(16'h0, 12'h020, r);
		chk(r, 32'hFFFF);
		// bulk erase: wrong last byte, then the real one
		erase_pre(12'h004);
		op(UNLK_ADDR1, 8'h11, 12'h004);
		chk({31'h0, busy}, 32'h0);
		rdf(16'h0, 12'h004, r);
		chk(r, {16'h0, dB});
		erase_pre(12'h004);
		op(UNLK_ADDR1, CMD_BULK, 12'h004);
		op(UNLK_ADDR1, CMD_RESET, 12'h004);
		chk({31'h0, busy}, 32'h1);
		poll(16'h0, 12'h004, s);
		chk(s, 32'h2);
		rdf(16'h0, 12'h004, r);
		chk(r, 32'hFFFF);
		// a program that times out reports the error bit
		forceFail <= 1'b1;
		prog(16'h2, 12'h004, dA);
		poll(16'h2, 12'h004, s);
		chk(s, 32'h4);
		forceFail <= 1'b0;
		op(UNLK_ADDR1, CMD_RESET, 12'h004);
		repeat (640) @(posedge ref_clk);
		chk({31'h0, busy}, 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
